//--- rtl/spi_err_pkg.sv
// constants and carrier types for the serial port error and low-power block
// Operation
// - master with select low sets mode fault
// - mode fault clears the port enable bit
// - mode fault clears master select, port becomes slave
// - fault clears by status read then control write
// - fault blocks enable/master writes except clearing write
// - slave never sets mode fault; old flag stays
// - byte completing with done set raises overrun
// - overrun keeps first byte, later bytes dropped
// - status read clears the overrun flag
// - data write during transfer discarded, transfer unaffected
// - discarded write sets collision flag, master or slave
// - collision flag never requests an interrupt
// - received bytes copied to separate read buffer
// - wait: port runs, events wake the processor
// - halt: registers frozen, port stops until wake
// - slave transfer done wakes from halt only
// - halt wake needs select low at halt entry
// - after wake, leaving slave restores normal at once
// - three events share one gated interrupt line
// - enable set, mask clear: request while done, overrun or fault flag set
// - soft select mode takes level from soft bit
package spi_err_pkg;

	// processor clock period and master serial half period
	localparam int CLK_PERIOD_PS = 8000;
	localparam int SCK_HALF_PS = 32000;
	// least half period, rounded up to whole processor cycles
	localparam int SCK_HALF_CYC = (SCK_HALF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [3:0] HALF_LAST = 4'(SCK_HALF_CYC - 1);

	// bit positions within a byte, msb first
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// synchroniser lane positions
	localparam int SYNC_SS = 0;
	localparam int SYNC_TGL = 1;
	localparam int SYNC_MISO = 2;
	localparam int SYNC_W = 3;
	// idle lane levels: select released high, toggle at its own reset level
	localparam logic [SYNC_W-1:0] SYNC_IDLE = 3'h1;

	// control word written by the processor
	typedef struct packed {
		logic serial_irq_enable;
		logic port_enable;
		logic master_select;
	} ctrl_s;

	// slave-select management bits
	typedef struct packed {
		logic soft_select_mode;
		logic soft_select_level;
	} select_s;

	// readable status flags
	typedef struct packed {
		logic transfer_done_flag;
		logic write_collision_flag;
		logic overrun_flag;
		logic mode_fault_flag;
	} status_s;

	// master shift sequencer
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_LOW = 2'b01,
		M_HIGH = 2'b10
	} master_e;

endpackage

//--- rtl/spi_err_port.sv
// serial port with mode fault, overrun, collision flags and wait/halt behaviour
`timescale 1ns/1ps
module spi_err_port (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic link_sclk,
	input wire spi_err_pkg::ctrl_s ctrl_wdata,
	input wire logic ctrl_wr,
	input wire spi_err_pkg::select_s select_wdata,
	input wire logic select_wr,
	input wire logic status_rd,
	input wire logic [7:0] data_wdata,
	input wire logic data_wr,
	input wire logic data_rd,
	input wire logic global_mask,
	input wire logic wait_mode,
	input wire logic halt_mode,
	input wire logic ss_n_in,
	input wire logic mosi_in,
	input wire logic miso_in,
	output spi_err_pkg::ctrl_s ctrl_q,
	output spi_err_pkg::select_s select_q,
	output spi_err_pkg::status_s status,
	output logic [7:0] data_reg,
	output logic irq,
	output logic wait_wake,
	output logic halt_wake,
	output logic port_normal,
	output logic sclk_out,
	output logic sclk_oe_n,
	output logic mosi_out,
	output logic mosi_oe_n,
	output logic miso_out,
	output logic miso_oe_n
);

	// register state
	spi_err_pkg::ctrl_s ctrl; // control word
	spi_err_pkg::select_s sel; // select management
	spi_err_pkg::status_s flags; // event flags
	logic [7:0] rx_buf; // processor-side receive buffer
	logic [7:0] tx_hold; // slave transmit byte
	logic done_armed; // status access seen while done set
	logic write_collision_flag_armed; // status access seen while collision set
	logic mode_fault_flag_armed; // status read seen while fault set
	logic halt_d; // halt sampled last cycle
	logic wake_armed; // select was low as halt began
	logic resync_pending; // slave needs one byte after wake

	// synchronisers: stage one feeds stage two only
	logic [spi_err_pkg::SYNC_W-1:0] sync_a;
	logic [spi_err_pkg::SYNC_W-1:0] sync_b;
	logic tgl_d; // delayed toggle for edge detect

	// master sequencer
	spi_err_pkg::master_e mstate;
	spi_err_pkg::master_e next_mstate;
	logic [3:0] half_cnt; // cycles within a half period
	logic [2:0] m_bit; // bit index within byte
	logic [7:0] m_shift; // master shift register
	logic m_sample; // bit caught on rising edge

	// link domain
	logic link_rst_n; // link held in reset when slave is idle
	logic [2:0] l_bit; // link bit counter
	logic [7:0] l_shift; // link receive shift
	logic [7:0] link_byte; // last completed byte, quasi-static
	logic link_tgl; // toggles once per completed byte
	logic miso_q; // bit driven after falling edge

	// decode wires
	wire run = !halt_mode;
	wire ss_int_s = sel.soft_select_mode ? sel.soft_select_level
		: sync_b[spi_err_pkg::SYNC_SS];
	wire ss_int_raw = sel.soft_select_mode ? sel.soft_select_level : ss_n_in;
	wire is_master = ctrl.port_enable && ctrl.master_select;
	wire is_slave = ctrl.port_enable && !ctrl.master_select;
	wire fault_evt = is_master && !ss_int_s && run;
	wire slave_busy = is_slave && !ss_int_s;
	wire busy = (mstate != spi_err_pkg::M_IDLE) || slave_busy;
	wire cpu_data_wr = data_wr && run;
	wire wr_collide = cpu_data_wr && busy;
	wire wr_inhibit = flags.transfer_done_flag && !done_armed;
	wire wr_ok = cpu_data_wr && !busy && !wr_inhibit;
	wire status_access = (status_rd || select_wr) && run;
	wire slave_done = (sync_b[spi_err_pkg::SYNC_TGL] ^ tgl_d) && is_slave;
	wire half_end = half_cnt == spi_err_pkg::HALF_LAST;
	wire master_done = (mstate == spi_err_pkg::M_HIGH) && half_end
		&& (m_bit == spi_err_pkg::BIT_LAST) && is_master;
	wire byte_done = slave_done || master_done;
	wire [7:0] byte_val = master_done ? {m_shift[6:0], m_sample} : link_byte;
	wire accept = byte_done && (run || wake_armed);
	wire to_buffer = accept && !flags.transfer_done_flag;
	wire to_overrun = accept && flags.transfer_done_flag;
	wire done_clear = done_armed && (data_rd || data_wr) && run;
	wire write_collision_flag_clear = write_collision_flag_armed && (data_rd || data_wr) && run;
	wire mode_fault_flag_clear = mode_fault_flag_armed && ctrl_wr && run;
	wire fault_block = flags.mode_fault_flag && !mode_fault_flag_armed;
	wire any_event = flags.transfer_done_flag || flags.overrun_flag || flags.mode_fault_flag;
	wire halt_enter = halt_mode && !halt_d;
	wire halt_exit = !halt_mode && halt_d;

	// processor-side synchronisers for pins and the link toggle;
	// toggle lane resets low like the link toggle, so no false byte edge follows reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= spi_err_pkg::SYNC_IDLE;
			sync_b <= spi_err_pkg::SYNC_IDLE;
			tgl_d <= 1'b0;
		end else begin
			sync_a <= {miso_in, link_tgl, ss_n_in};
			sync_b <= sync_a;
			tgl_d <= sync_b[spi_err_pkg::SYNC_TGL];
		end
	end

	// control word; fault wins over any write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= '0;
		end else if (fault_evt) begin
			ctrl.port_enable <= 1'b0;
			ctrl.master_select <= 1'b0;
		end else if (ctrl_wr && run) begin
			ctrl.serial_irq_enable <= ctrl_wdata.serial_irq_enable;
			// set attempts ignored while fault pending, clears still taken
			ctrl.port_enable <= ctrl_wdata.port_enable && !fault_block;
			ctrl.master_select <= ctrl_wdata.master_select && !fault_block;
		end
	end

	// select management bits
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sel <= '0;
		end else if (select_wr && run) begin
			sel <= select_wdata;
		end
	end

	// clearing-sequence arms, each drops when its flag drops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			done_armed <= 1'b0;
			write_collision_flag_armed <= 1'b0;
			mode_fault_flag_armed <= 1'b0;
		end else begin
			done_armed <= flags.transfer_done_flag && !done_clear
				&& (done_armed || status_access);
			write_collision_flag_armed <= flags.write_collision_flag && !write_collision_flag_clear
				&& (write_collision_flag_armed || status_access);
			mode_fault_flag_armed <= flags.mode_fault_flag && !mode_fault_flag_clear
				&& (mode_fault_flag_armed || (status_rd && run));
		end
	end

	// event flags; a set in the clearing cycle wins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= '0;
		end else begin
			flags.transfer_done_flag <= to_buffer
				|| (flags.transfer_done_flag && !done_clear);
			flags.overrun_flag <= to_overrun
				|| (flags.overrun_flag && !(status_rd && run));
			flags.write_collision_flag <= wr_collide
				|| (flags.write_collision_flag && !write_collision_flag_clear);
			flags.mode_fault_flag <= fault_evt
				|| (flags.mode_fault_flag && !mode_fault_flag_clear);
		end
	end

	// receive buffer: only the first byte after clearing lands here
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_buf <= spi_err_pkg::BYTE_RESET;
		end else if (to_buffer) begin
			rx_buf <= byte_val;
		end
	end

	// slave transmit byte; held still while selected so the link may read it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_hold <= spi_err_pkg::BYTE_RESET;
		end else if (wr_ok && !ctrl.master_select) begin
			tx_hold <= data_wdata;
		end
	end

	// master sequencer next state
	always_comb begin
		next_mstate = mstate;
		case (mstate)
			spi_err_pkg::M_IDLE: begin
				if (wr_ok && is_master) begin
					next_mstate = spi_err_pkg::M_LOW;
				end
			end
			spi_err_pkg::M_LOW: begin
				if (half_end) begin
					next_mstate = spi_err_pkg::M_HIGH;
				end
			end
			spi_err_pkg::M_HIGH: begin
				if (half_end) begin
					next_mstate = (m_bit == spi_err_pkg::BIT_LAST) ? spi_err_pkg::M_IDLE
						: spi_err_pkg::M_LOW;
				end
			end
			default: begin
				next_mstate = spi_err_pkg::M_IDLE;
			end
		endcase
		// losing master role or enable aborts the byte
		if (!is_master) begin
			next_mstate = spi_err_pkg::M_IDLE;
		end
	end

	// master state; halt freezes it in place
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mstate <= spi_err_pkg::M_IDLE;
		end else if (run || !is_master) begin
			mstate <= next_mstate;
		end
	end

	// master half-period counter and bit index
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			half_cnt <= 4'h0;
			m_bit <= spi_err_pkg::BIT_FIRST;
		end else if (mstate == spi_err_pkg::M_IDLE) begin
			half_cnt <= 4'h0;
			m_bit <= spi_err_pkg::BIT_FIRST;
		end else if (run) begin
			half_cnt <= half_end ? 4'h0 : half_cnt + 4'h1;
			if (mstate == spi_err_pkg::M_HIGH && half_end) begin
				m_bit <= m_bit + 3'h1;
			end
		end
	end

	// master shifter: sample on rise, shift on fall
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			m_shift <= spi_err_pkg::BYTE_RESET;
			m_sample <= 1'b0;
		end else if (mstate == spi_err_pkg::M_IDLE) begin
			if (wr_ok && is_master) begin
				m_shift <= data_wdata;
			end
		end else if (run && half_end) begin
			if (mstate == spi_err_pkg::M_LOW) begin
				m_sample <= sync_b[spi_err_pkg::SYNC_MISO];
			end else begin
				m_shift <= {m_shift[6:0], m_sample};
			end
		end
	end

	// master pins come straight from flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_out <= 1'b0;
			mosi_out <= 1'b0;
		end else begin
			sclk_out <= (next_mstate == spi_err_pkg::M_HIGH);
			mosi_out <= (next_mstate == spi_err_pkg::M_IDLE) ? 1'b0
				: (mstate == spi_err_pkg::M_IDLE) ? data_wdata[7] : m_shift[7];
		end
	end

	// halt bookkeeping: catch select level on entry, mark slave for resync
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			halt_d <= 1'b0;
			wake_armed <= 1'b0;
			resync_pending <= 1'b0;
		end else begin
			halt_d <= halt_mode;
			if (halt_enter) begin
				wake_armed <= is_slave && !ss_int_s;
			end else if (!halt_mode) begin
				wake_armed <= 1'b0;
			end
			// a port still slave after wake needs one more byte
			if (halt_exit && wake_armed && is_slave) begin
				resync_pending <= 1'b1;
			end else if (!is_slave || (accept && run)) begin
				resync_pending <= 1'b0;
			end
		end
	end

	// link side resets whenever the slave is not selected or not enabled;
	// this keeps the bit counter aligned to byte boundaries without a crossing
	assign link_rst_n = rst_n && is_slave && !ss_int_raw;

	// link receive shift, sampled on rising serial clock
	always_ff @(posedge link_sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			l_bit <= spi_err_pkg::BIT_FIRST;
			l_shift <= spi_err_pkg::BYTE_RESET;
		end else begin
			l_shift <= {l_shift[6:0], mosi_in};
			l_bit <= l_bit + 3'h1;
		end
	end

	// completed byte and toggle survive select going high
	always_ff @(posedge link_sclk or negedge rst_n) begin
		if (!rst_n) begin
			link_byte <= spi_err_pkg::BYTE_RESET;
			link_tgl <= 1'b0;
		end else if (link_rst_n && l_bit == spi_err_pkg::BIT_LAST) begin
			link_byte <= {l_shift[6:0], mosi_in};
			link_tgl <= !link_tgl;
		end
	end

	// slave output bit moves on the falling serial clock
	always_ff @(negedge link_sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			miso_q <= 1'b0;
		end else begin
			miso_q <= tx_hold[3'(spi_err_pkg::BIT_LAST - l_bit)];
		end
	end

	// first bit must stand before the first rising edge
	assign miso_out = (l_bit == spi_err_pkg::BIT_FIRST) ? tx_hold[7] : miso_q;

	// pin enables, low while driving; cleared enable silences all output
	assign sclk_oe_n = !is_master;
	assign mosi_oe_n = !is_master;
	assign miso_oe_n = !slave_busy;

	// shared interrupt and wake outputs; collision is status only
	assign irq = ctrl.serial_irq_enable && any_event && !global_mask;
	assign wait_wake = wait_mode && irq;
	assign halt_wake = halt_mode && wake_armed && flags.transfer_done_flag
		&& ctrl.serial_irq_enable && !global_mask;

	// readable state
	assign ctrl_q = ctrl;
	assign select_q = sel;
	assign status = flags;
	assign data_reg = rx_buf;
	assign port_normal = !resync_pending;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	AST_MODE_FAULT_FLAG_SET: assert property (fault_evt |=> flags.mode_fault_flag)
		else $error("mode fault not flagged");
	AST_PE_DROP: assert property (fault_evt |=> !ctrl.port_enable && sclk_oe_n)
		else $error("port enable survived a mode fault");
	AST_MASTER_SELECT_DROP: assert property (fault_evt |=> !ctrl.master_select)
		else $error("master select survived a mode fault");
	AST_MODE_FAULT_FLAG_HOLD: assert property (flags.mode_fault_flag
		&& !(ctrl_wr && mode_fault_flag_armed && run) |=> flags.mode_fault_flag)
		else $error("mode fault cleared without sequence");
	AST_FAULT_BLOCK: assert property (fault_block && ctrl_wr && !ctrl.port_enable
		|=> !ctrl.port_enable ##1 !ctrl.port_enable || ctrl_wr)
		else $error("enable set while fault pending");
	AST_SLAVE_NO_MODE_FAULT_FLAG: assert property (!ctrl.master_select && !flags.mode_fault_flag
		|=> !flags.mode_fault_flag)
		else $error("slave set mode fault");
	AST_OVR_SET: assert property (accept && flags.transfer_done_flag
		|=> flags.overrun_flag && $stable(rx_buf))
		else $error("overrun missed or buffer overwritten");
	AST_OVR_CLEAR: assert property (status_rd && run && !to_overrun |=> !flags.overrun_flag)
		else $error("overrun survived status read");
	AST_WRITE_COLLISION_FLAG: assert property (wr_collide |=> flags.write_collision_flag
		&& $stable(tx_hold)
		&& !(mstate == spi_err_pkg::M_LOW && $past(mstate) == spi_err_pkg::M_IDLE))
		else $error("collision write not discarded");
	AST_WRITE_COLLISION_FLAG_NO_IRQ: assert property (flags.write_collision_flag && !any_event |-> !irq)
		else $error("collision raised interrupt");
	AST_HALT_WAKE: assert property (halt_wake |-> wake_armed && $past(halt_mode))
		else $error("halt wake without armed select");

	COV_FAULT: cover property (fault_evt ##1 mode_fault_flag_clear);
	COV_OVERRUN: cover property (to_buffer ##[1:200] to_overrun);
	COV_COLLIDE: cover property (wr_collide);
	COV_HALT_WAKE: cover property (halt_enter ##[1:400] halt_wake);

endmodule

//--- verif/spi_err_port_tb.sv
// self-checking bench for the serial port error and low-power block
`timescale 1ns/1ps
module spi_err_port_tb;
	logic mclk, rst_n, ctrl_wr, select_wr, status_rd, data_wr, data_rd;
	logic global_mask, wait_mode, halt_mode;
	logic link_sclk, mosi_in, ss_n_in; // driven by the far-side model
	logic [7:0] data_wdata, data_reg;
	spi_err_pkg::ctrl_s ctrl_wdata, ctrl_q;
	spi_err_pkg::select_s select_wdata, select_q;
	spi_err_pkg::status_s status;
	logic irq, wait_wake, halt_wake, port_normal;
	logic sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0; // watchdog count

	// master data loops back into its own input, so a master byte returns itself
	spi_err_port spi_err_port_inst (.mclk(mclk), .rst_n(rst_n), .link_sclk(link_sclk),
		.ctrl_wdata(ctrl_wdata), .ctrl_wr(ctrl_wr), .select_wdata(select_wdata),
		.select_wr(select_wr), .status_rd(status_rd), .data_wdata(data_wdata),
		.data_wr(data_wr), .data_rd(data_rd), .global_mask(global_mask),
		.wait_mode(wait_mode), .halt_mode(halt_mode), .ss_n_in(ss_n_in),
		.mosi_in(mosi_in), .miso_in(mosi_out), .ctrl_q(ctrl_q), .select_q(select_q),
		.status(status), .data_reg(data_reg), .irq(irq), .wait_wake(wait_wake),
		.halt_wake(halt_wake), .port_normal(port_normal), .sclk_out(sclk_out),
		.sclk_oe_n(sclk_oe_n), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
		.miso_out(miso_out), .miso_oe_n(miso_oe_n));

	spi_link_master spi_link_master_inst (.link_sclk(link_sclk), .mosi_in(mosi_in),
		.ss_n_in(ss_n_in), .miso_out(miso_out));

	// 125 MHz processor clock
	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end

	// hang guard: the whole run needs a few hundred cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// wait n edges, then let their updates land before sampling
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %b", $time, what, got);
		end
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h", $time, what, got);
		end
	endtask

	// one-cycle strobe: 0 control, 1 select bits, 2 status read, 3 data write, 4 data read
	task automatic op(input int k, input logic [7:0] d);
		@(posedge mclk);
		ctrl_wdata <= spi_err_pkg::ctrl_s'(d[2:0]);
		select_wdata <= spi_err_pkg::select_s'(d[1:0]);
		data_wdata <= d;
		case (k)
			0: ctrl_wr <= 1'h1;
			1: select_wr <= 1'h1;
			2: status_rd <= 1'h1;
			3: data_wr <= 1'h1;
			default: data_rd <= 1'h1;
		endcase
		@(posedge mclk);
		{ctrl_wr, select_wr, status_rd, data_wr, data_rd} <= 5'h00;
		#1;
	endtask

	// bounded wait for the transfer flag
	task automatic wait_done();
		int k;
		for (k = 0; k < 60 && status.transfer_done_flag !== 1'h1; k++)
			tick(1);
		chk_bit(status.transfer_done_flag, 1'h1, "done flag");
	endtask

	// slave receive, collision mid-frame, overrun, wait and mask behaviour
	task automatic t_slave();
		op(0, 8'h06); // slave, enabled, irq enable
		op(3, 8'h5A); // tx byte loaded with select high
		fork
			spi_link_master_inst.send(8'hC3);
			begin
				tick(20);
				op(3, 8'hFF);
				tick(2);
				chk_bit(status.write_collision_flag, 1'h1, "collision");
				chk_bit(irq, 1'h0, "irq on collision");
				chk_bit(miso_oe_n, 1'h0, "slave drives data");
			end
		join
		wait_done();
		chk_byte(spi_link_master_inst.rx, 8'h5A, "slave tx byte");
		chk_byte(data_reg, 8'hC3, "rx buffer");
		chk_bit(irq, 1'h1, "irq on done");
		spi_link_master_inst.send(8'h3C);
		tick(6);
		chk_bit(status.overrun_flag, 1'h1, "overrun");
		chk_byte(data_reg, 8'hC3, "first byte kept");
		@(posedge mclk) wait_mode <= 1'h1;
		tick(2);
		chk_bit(wait_wake, 1'h1, "wait wake");
		@(posedge mclk) global_mask <= 1'h1;
		tick(2);
		chk_bit(irq, 1'h0, "masked irq");
		@(posedge mclk) {global_mask, wait_mode} <= 2'h0;
		op(2, 8'h00);
		tick(1);
		chk_bit(status.overrun_flag, 1'h0, "overrun clear");
		op(4, 8'h00);
		tick(1);
		chk_bit(status.transfer_done_flag, 1'h0, "done clear");
		chk_bit(status.write_collision_flag, 1'h0, "collision clear");
		$display("test slave done");
	endtask

	// mode fault set, blocked rewrite, clearing sequence, slave immunity
	task automatic t_fault();
		op(0, 8'h07);
		tick(3);
		chk_bit(sclk_oe_n, 1'h0, "master drives clock");
		spi_link_master_inst.set_select(1'h0);
		tick(6);
		chk_bit(status.mode_fault_flag, 1'h1, "fault");
		chk_bit(irq, 1'h1, "fault irq");
		chk_bit(ctrl_q.port_enable, 1'h0, "enable dropped");
		chk_bit(ctrl_q.master_select, 1'h0, "master dropped");
		spi_link_master_inst.set_select(1'h1);
		tick(4);
		op(0, 8'h07);
		tick(1);
		chk_bit(ctrl_q.port_enable, 1'h0, "blocked enable");
		chk_bit(status.mode_fault_flag, 1'h1, "fault held");
		op(2, 8'h00);
		op(0, 8'h07);
		tick(1);
		chk_bit(status.mode_fault_flag, 1'h0, "fault cleared");
		chk_bit(ctrl_q.master_select, 1'h1, "master restored");
		op(0, 8'h06);
		spi_link_master_inst.set_select(1'h0);
		tick(6);
		chk_bit(status.mode_fault_flag, 1'h0, "slave no fault");
		spi_link_master_inst.set_select(1'h1);
		$display("test fault done");
	endtask

	// halt entry with select low, frozen registers, wake on slave byte
	task automatic t_halt();
		spi_link_master_inst.set_select(1'h0);
		tick(4);
		@(posedge mclk) halt_mode <= 1'h1;
		tick(2);
		op(0, 8'h00);
		chk_bit(ctrl_q.port_enable, 1'h1, "frozen in halt");
		spi_link_master_inst.send(8'hA5);
		wait_done();
		chk_bit(halt_wake, 1'h1, "halt wake");
		chk_byte(data_reg, 8'hA5, "halt rx byte");
		@(posedge mclk) halt_mode <= 1'h0;
		tick(2);
		chk_bit(port_normal, 1'h0, "slave after wake");
		op(1, 8'h03); // soft select, deselected
		op(0, 8'h07);
		tick(1);
		chk_bit(port_normal, 1'h1, "left slave");
		chk_bit(select_q.soft_select_mode, 1'h1, "soft select");
		$display("test halt done");
	endtask

	// master byte looped back, collision mid-byte, master pins driven
	task automatic t_master();
		op(4, 8'h00); // finishes the done clear armed by the select write
		chk_bit(status.transfer_done_flag, 1'h0, "done clear before master");
		op(3, 8'h96);
		tick(4);
		chk_bit(mosi_oe_n, 1'h0, "master drives data");
		chk_bit(sclk_out, 1'h1, "first high half");
		chk_bit(mosi_out, 1'h1, "first bit out");
		tick(3);
		op(3, 8'hFF);
		tick(1);
		chk_bit(status.write_collision_flag, 1'h1, "master collision");
		wait_done();
		chk_byte(data_reg, 8'h96, "looped byte");
		chk_bit(irq, 1'h1, "irq on master done");
		$display("test master done");
	endtask

	// reset, then the scenarios in turn
	initial begin
		rst_n = 1'h0;
		{ctrl_wr, select_wr, status_rd, data_wr, data_rd} = 5'h00;
		{global_mask, wait_mode, halt_mode} = 3'h0;
		ctrl_wdata = '0;
		select_wdata = '0;
		data_wdata = 8'h00;
		repeat (20) @(posedge mclk);
		rst_n <= 1'h1;
		tick(3);
		chk_bit(port_normal, 1'h1, "reset normal");
		t_slave();
		t_fault();
		t_halt();
		t_master();
		give_verdict();
	end
endmodule

//--- verif/spi_link_master.sv
// behavioural far-side serial master for the error-flag port bench
`timescale 1ns/1ps
module spi_link_master (
	output logic link_sclk,
	output logic mosi_in,
	output logic ss_n_in,
	input wire logic miso_out
);
	logic [7:0] rx; // byte shifted back from the port

	// idle: clock parked low, select released high
	initial begin
		link_sclk = 1'h0;
		mosi_in = 1'h0;
		ss_n_in = 1'h1;
		rx = 8'h00;
	end

	// select level outside frames; held high while the bench clears a fault
	task automatic set_select(input logic lvl);
		ss_n_in = lvl;
	endtask

	// one mode 0 frame, msb first, 32 ns clock that runs only in the frame
	task automatic send(input logic [7:0] b);
		int i;
		ss_n_in = 1'h0;
		#40;
		for (i = 7; i >= 0; i--) begin
			mosi_in = b[i];
			#16 link_sclk = 1'h1;
			rx = {rx[6:0], miso_out};
			#16 link_sclk = 1'h0;
		end
		// no pull on the data line: show the inverse once released
		mosi_in = ~b[0];
		#40 ss_n_in = 1'h1;
	endtask
endmodule
